// File: logic/fault_pkg.sv
package fault_pkg;

    // clock: 200 MHz, period in picoseconds
    localparam longint CLK_PS     = 64'd5000;
    localparam longint PS_PER_NS  = 64'd1000;
    localparam longint PS_PER_US  = 64'd1000000;
    localparam longint PS_PER_MS  = 64'd1000000000;

    // overload integration time (least time: round up)
    localparam longint OVLD_MS    = 64'd160;
    localparam longint OVLD_CYC   = (OVLD_MS * PS_PER_MS + CLK_PS - 1) / CLK_PS;
    // short blanking ahead of the abnormal current comparator (round up)
    localparam longint BLANK_NS   = 64'd125;
    localparam longint BLANK_CYC  = (BLANK_NS * PS_PER_NS + CLK_PS - 1)
                                    / CLK_PS;
    // longest gate on-phase (longest time: round down)
    localparam longint TON_US     = 64'd32;
    localparam longint TON_CYC    = (TON_US * PS_PER_US) / CLK_PS;
    // auto-recovery interval (least time: round up)
    localparam longint AR_MS      = 64'd1200;
    localparam longint AR_CYC     = (AR_MS * PS_PER_MS + CLK_PS - 1) / CLK_PS;
    // valley timeout, no figure available: plain default in cycles
    localparam longint VALLEY_CYC = 64'd1000;

    // consecutive abnormal current events before latch-off
    localparam int     ABNORMAL_OVERCURRENT_PROTECTION_W     = 3;
    localparam logic [ABNORMAL_OVERCURRENT_PROTECTION_W-1:0] ABNORMAL_OVERCURRENT_PROTECTION_LIMIT = 3'h4;

    // register port
    localparam int     ADDR_W     = 4;
    localparam int     DATA_W     = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL  = 4'h0;
    localparam logic [ADDR_W-1:0] REG_STATE = 4'h1;
    localparam logic [ADDR_W-1:0] REG_ISTAT = 4'h2;
    localparam logic [ADDR_W-1:0] REG_IMASK = 4'h3;

    // control fields
    localparam int     CTRL_LATCH = 0;
    localparam int     CTRL_EN    = 1;
    localparam logic [DATA_W-1:0] CTRL_RST  = 8'h03;

    // event bits, shared by status and mask
    localparam int     NUM_EV     = 5;
    localparam int     EV_OVLD    = 0;
    localparam int     EV_ABNORMAL_OVERCURRENT_PROTECTION    = 1;
    localparam int     EV_OVP     = 2;
    localparam int     EV_THERM   = 3;
    localparam int     EV_TON     = 4;

    typedef enum logic [4:0] {
        ST_OFF     = 5'h01,
        ST_RUN     = 5'h02,
        ST_LATCH   = 5'h04,
        ST_AUTOREC = 5'h08,
        ST_THERM   = 5'h10
    } state_e;

endpackage

// File: logic/flyback_fault_protection.sv
// Local design decisions: the placing of the registers and strobed register access.
`timescale 1ns/1ps
module flyback_fault_protection #(
    parameter int OVLD_CYCLES   = int'(fault_pkg::OVLD_CYC),
    parameter int TON_CYCLES    = int'(fault_pkg::TON_CYC),
    parameter int AR_CYCLES     = int'(fault_pkg::AR_CYC),
    parameter int VALLEY_CYCLES = int'(fault_pkg::VALLEY_CYC)
) (
    // clock and reset
    input  logic                          sys_clk,
    input  logic                          reset,
    // register port
    input  logic [fault_pkg::ADDR_W-1:0]  regAddr,
    input  logic [fault_pkg::DATA_W-1:0]  regWrData,
    input  logic                          regWr,
    input  logic                          regRd,
    output logic [fault_pkg::DATA_W-1:0]  regRdData,
    // comparator flags
    input  logic                          overloadFault,
    input  logic                          normalCurrentTrip,
    input  logic                          abnormalCurrentTrip,
    input  logic                          demagArmed,
    input  logic                          demagDetectInput,
    input  logic                          supplyOvervoltage,
    input  logic                          overTemp,
    input  logic                          supplyStart,
    input  logic                          supplyReset,
    input  logic                          lineRemoval,
    // outputs
    output logic                          gateDriveOutput,
    output logic                          faultLatched,
    output logic                          autoRecovery,
    output logic                          irq
);
    import fault_pkg::*;

    localparam int BLANK = int'(BLANK_CYC);

    ////////////////////////////////////////////////////////////////////
    state_e              state_q;
    state_e              state_d;
    logic [DATA_W-1:0]   ctrl_q;
    logic [DATA_W-1:0]   ctrl_d;
    logic                drvOn_q;
    logic                drvOn_d;
    logic                aocpSeen_q;
    logic                aocpSeen_d;
    logic [ABNORMAL_OVERCURRENT_PROTECTION_W-1:0]   aocpCnt_q;
    logic [ABNORMAL_OVERCURRENT_PROTECTION_W-1:0]   aocpCnt_d;
    logic                latched_q;
    logic                arMode_q;
    logic                blankDone;
    logic                tonDone;
    logic                valleyDone;
    logic                arDone;
    logic                aocpHit;
    logic                pulseEnd;
    logic                leave;
    integ_if             ovld ();

    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // timers
    assign ovld.up = (state_q == ST_RUN) && overloadFault;

    overload_integrator #(.LIMIT(OVLD_CYCLES)) u_ovld (
        .sys_clk (sys_clk),
        .reset   (reset),
        .io      (ovld.cnt)
    );

    limit_timer #(.LIMIT(BLANK)) u_blank (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (drvOn_q),
        .done    (blankDone)
    );

    // limit one short of the figure: drive falls on the next edge
    limit_timer #(.LIMIT(TON_CYCLES - 1)) u_ton (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (drvOn_q),
        .done    (tonDone)
    );

    // held cleared while demag is armed: leakage ringing would else
    // let the timeout fire into a saturating core
    limit_timer #(.LIMIT(VALLEY_CYCLES - 1)) u_valley (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     ((state_q == ST_RUN) && !drvOn_q && !demagArmed),
        .done    (valleyDone)
    );

    limit_timer #(.LIMIT(AR_CYCLES - 1)) u_ar (
        .sys_clk (sys_clk),
        .reset   (reset),
        .run     (state_q == ST_AUTOREC),
        .done    (arDone)
    );

    ////////////////////////////////////////////////////////////////////
    // fault state and gate drive
    assign leave    = supplyReset || lineRemoval;
    assign aocpHit  = drvOn_q && blankDone && abnormalCurrentTrip;
    assign pulseEnd = drvOn_q && !drvOn_d;

    always_comb begin
        state_d    = state_q;
        drvOn_d    = drvOn_q;
        aocpSeen_d = 1'b0;
        aocpCnt_d  = aocpCnt_q;
        case (state_q)
            ST_OFF: begin
                if (supplyOvervoltage && !leave) begin
                    state_d = ST_LATCH;
                end else if (supplyStart && ctrl_q[CTRL_EN] &&
                    !supplyOvervoltage &&
                    !overTemp && !lineRemoval) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                if (leave) begin
                    state_d = ST_OFF;
                end else if (supplyOvervoltage) begin
                    state_d = ST_LATCH;
                end else if (aocpCnt_q == ABNORMAL_OVERCURRENT_PROTECTION_LIMIT) begin
                    state_d = ST_LATCH;
                end else if (overTemp) begin
                    state_d = ST_THERM;
                end else if (ovld.expired) begin
                    state_d = ctrl_q[CTRL_LATCH] ? ST_LATCH
                                                 : ST_AUTOREC;
                end
            end
            ST_LATCH: begin
                if (leave) begin
                    state_d = ST_OFF;
                end
            end
            ST_AUTOREC: begin
                if (leave) begin
                    state_d = ST_OFF;
                end else if (supplyOvervoltage) begin
                    state_d = ST_LATCH;
                end else if (arDone && supplyStart && !overTemp) begin
                    state_d = ST_RUN;
                end
            end
            ST_THERM: begin
                if (leave) begin
                    state_d = ST_OFF;
                end else if (supplyOvervoltage) begin
                    state_d = ST_LATCH;
                end else if (supplyStart && !overTemp) begin
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_OFF;
            end
        endcase

        // drive only while running now and next cycle
        if (state_q != ST_RUN || state_d != ST_RUN) begin
            drvOn_d = 1'b0;
        end else if (drvOn_q) begin
            if (normalCurrentTrip || aocpHit || tonDone) begin
                drvOn_d = 1'b0;
            end
        end else if (demagDetectInput || valleyDone) begin
            drvOn_d = 1'b1;
        end

        if (drvOn_q) begin
            aocpSeen_d = aocpSeen_q || aocpHit;
        end
        if (state_q != ST_RUN) begin
            aocpCnt_d = '0;
        end else if (drvOn_q && !drvOn_d) begin
            if (aocpSeen_q || aocpHit) begin
                if (aocpCnt_q != ABNORMAL_OVERCURRENT_PROTECTION_LIMIT) begin
                    aocpCnt_d = aocpCnt_q + 1'b1;
                end
            end else begin
                aocpCnt_d = '0;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            state_q    <= ST_OFF;
            drvOn_q    <= 1'b0;
            aocpSeen_q <= 1'b0;
            aocpCnt_q  <= '0;
            latched_q  <= 1'b0;
            arMode_q   <= 1'b0;
        end else begin
            state_q    <= state_d;
            drvOn_q    <= drvOn_d;
            aocpSeen_q <= aocpSeen_d;
            aocpCnt_q  <= aocpCnt_d;
            latched_q  <= (state_d == ST_LATCH);
            arMode_q   <= (state_d == ST_AUTOREC);
        end
    end

    assign gateDriveOutput = drvOn_q;
    assign faultLatched    = latched_q;
    assign autoRecovery    = arMode_q;

    ////////////////////////////////////////////////////////////////////
    // registers and interrupt
    logic [NUM_EV-1:0] istat_q;
    logic [NUM_EV-1:0] istat_d;
    logic [NUM_EV-1:0] imask_q;
    logic [NUM_EV-1:0] imask_d;
    logic [NUM_EV-1:0] ev;
    logic [DATA_W-1:0] rd_q;
    logic [DATA_W-1:0] rd_d;
    logic              irq_q;
    logic              irq_d;

    always_comb begin
        ev           = '0;
        ev[EV_OVLD]  = (state_q == ST_RUN) && ovld.expired;
        ev[EV_ABNORMAL_OVERCURRENT_PROTECTION]  = pulseEnd && (aocpSeen_q || aocpHit);
        ev[EV_OVP]   = supplyOvervoltage && (state_q != ST_LATCH);
        ev[EV_THERM] = (state_q == ST_RUN) && (state_d == ST_THERM);
        ev[EV_TON]   = drvOn_q && tonDone;
        ctrl_d  = ctrl_q;
        imask_d = imask_q;
        istat_d = istat_q;
        rd_d    = '0;
        if (regWr && hit(regAddr, REG_CTRL)) begin
            ctrl_d = regWrData;
        end
        if (regWr && hit(regAddr, REG_IMASK)) begin
            imask_d = regWrData[NUM_EV-1:0];
        end
        if (regRd) begin
            case (regAddr)
                REG_CTRL:  rd_d = ctrl_q;
                REG_STATE: rd_d = {2'h0, drvOn_q, state_q};
                REG_ISTAT: rd_d = DATA_W'(istat_q);
                REG_IMASK: rd_d = DATA_W'(imask_q);
                default:   rd_d = '0;
            endcase
        end
        // a read clears, but an event in the same cycle still sets
        if (regRd && hit(regAddr, REG_ISTAT)) begin
            istat_d = '0;
        end
        istat_d = istat_d | ev;
        irq_d   = |(istat_d & imask_d);
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            ctrl_q  <= CTRL_RST;
            imask_q <= '0;
            istat_q <= '0;
            rd_q    <= '0;
            irq_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            imask_q <= imask_d;
            istat_q <= istat_d;
            rd_q    <= rd_d;
            irq_q   <= irq_d;
        end
    end

    assign regRdData = rd_q;
    assign irq       = irq_q;

    ////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    sequence pulseStart;
        $rose(drvOn_q);
    endsequence
    // a later pulse may already run BLANK cycles on, so the check looks
    // back from the end of blanking to the start of its own pulse
    sequence blankWindow;
        $past(drvOn_q, BLANK) && !$past(drvOn_q, BLANK + 1);
    endsequence

    chk_blank_window: assert property (
        (pulseStart |-> !blankDone) and ($rose(blankDone) |-> blankWindow))
        else $error("short blanking length wrong");
    chk_blank_ignore: assert property (
        drvOn_q && !blankDone && !normalCurrentTrip && !tonDone &&
        state_d == ST_RUN |=> drvOn_q)
        else $error("abnormal trip acted inside blanking");
    chk_ovp_latch: assert property (
        supplyOvervoltage && !leave |=> !drvOn_q && state_q == ST_LATCH)
        else $error("overvoltage did not latch");
    chk_ton_limit: assert property (
        drvOn_q && tonDone |=> !drvOn_q)
        else $error("on-phase passed its limit");
    chk_abnormal_overcurrent_protection_latch: assert property (
        state_q == ST_RUN && aocpCnt_q == ABNORMAL_OVERCURRENT_PROTECTION_LIMIT && !leave
        |=> state_q == ST_LATCH)
        else $error("abnormal count did not latch");
    chk_abnormal_overcurrent_protection_clear: assert property (
        state_q == ST_RUN && pulseEnd && !aocpSeen_q && !aocpHit
        |=> aocpCnt_q == '0)
        else $error("clean pulse left count");
    chk_valley_hold: assert property (
        demagArmed |=> !valleyDone)
        else $error("valley timeout ran while armed");
    chk_ovld_action: assert property (
        state_q == ST_RUN && ovld.expired && !leave && !overTemp &&
        !supplyOvervoltage && aocpCnt_q != ABNORMAL_OVERCURRENT_PROTECTION_LIMIT
        |=> state_q == ($past(ctrl_q[CTRL_LATCH]) ? ST_LATCH : ST_AUTOREC))
        else $error("overload expiry action wrong");
    chk_latch_hold: assert property (
        state_q == ST_LATCH && !leave |=> state_q == ST_LATCH)
        else $error("latched state left early");
    chk_therm_wait: assert property (
        state_q == ST_THERM && overTemp |=> state_q != ST_RUN)
        else $error("thermal restart while hot");
    chk_ar_wait: assert property (
        state_q == ST_AUTOREC && !arDone |=> state_q != ST_RUN && !drvOn_q)
        else $error("auto-recovery restarted early");
endmodule

// File: logic/integ_if.sv
`timescale 1ns/1ps
interface integ_if;
    logic up;
    logic expired;
    modport ctl (output up, input  expired);
    modport cnt (input  up, output expired);
endinterface

// File: logic/limit_timer.sv
`timescale 1ns/1ps
module limit_timer #(
    parameter int LIMIT = 25,
    parameter int W     = $clog2(LIMIT + 1)
) (
    // clock and reset
    input  logic sys_clk,
    input  logic reset,
    // control
    input  logic run,
    output logic done
);
    logic [W-1:0] cnt_q;
    logic [W-1:0] cnt_d;

    // dropping run clears the count, so each run starts afresh
    always_comb begin
        cnt_d = cnt_q;
        if (!run) begin
            cnt_d = '0;
        end else if (cnt_q != W'(LIMIT)) begin
            cnt_d = cnt_q + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign done = (cnt_q == W'(LIMIT));
endmodule

// File: logic/overload_integrator.sv
`timescale 1ns/1ps
module overload_integrator #(
    parameter int LIMIT = 32000000,
    parameter int W     = $clog2(LIMIT + 1)
) (
    // clock and reset
    input  logic sys_clk,
    input  logic reset,
    // integration control
    integ_if.cnt io
);
    logic [W-1:0] level_q;
    logic [W-1:0] level_d;

    // counts down after the fault, so short repeated bursts add up
    always_comb begin
        level_d = level_q;
        if (io.up) begin
            if (level_q != W'(LIMIT)) begin
                level_d = level_q + 1'b1;
            end
        end else if (level_q != '0) begin
            level_d = level_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            level_q <= '0;
        end else begin
            level_q <= level_d;
        end
    end

    assign io.expired = (level_q == W'(LIMIT));

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    chk_ovld_saturate: assert property (
        (level_q == '0 && !io.up |=> level_q == '0) and
        (io.expired && io.up |=> io.expired))
        else $error("overload integrator wrapped");
    chk_ovld_integrate: assert property (
        (io.up && !io.expired |=> level_q == $past(level_q) + 1'b1) and
        (!io.up && level_q != '0 |=> level_q == $past(level_q) - 1'b1))
        else $error("overload integrator step wrong");
endmodule

// File: testbench/fault_partner.sv
`timescale 1ns/1ps
module fault_partner (
    // clock and reset
    input  wire logic       sys_clk,
    input  wire logic       reset,
    // gate from the block and bench settings
    input  wire logic       gateDriveOutput,
    input  wire logic [7:0] tripAt,
    input  wire logic [7:0] abnAt,
    input  wire logic       abnEn,
    input  wire logic       detectEn,
    input  wire logic       armHold,
    // comparator flags
    output logic            normalCurrentTrip,
    output logic            abnormalCurrentTrip,
    output logic            demagArmed,
    output logic            demagDetectInput
);
    logic [7:0] onCnt_q;
    logic [7:0] onCnt_d;
    logic [7:0] offCnt_q;
    logic [7:0] offCnt_d;

    always_comb begin
        onCnt_d  = gateDriveOutput ? onCnt_q + 8'h01 : 8'h00;
        offCnt_d = gateDriveOutput ? 8'h00 : offCnt_q + 8'h01;
    end

    always_ff @(posedge sys_clk) begin
        onCnt_q  <= reset ? 8'h00 : onCnt_d;
        offCnt_q <= reset ? 8'h00 : offCnt_d;
    end

    ////////////////////////////////////////////////////////////////////////
    // sensed current exists only while the switch conducts
    assign normalCurrentTrip   = gateDriveOutput && onCnt_q == tripAt;
    assign abnormalCurrentTrip = gateDriveOutput && abnEn
                                 && onCnt_q == abnAt;
    // a held arming level means no valley is ever seen
    assign demagArmed          = armHold;
    assign demagDetectInput    = detectEn && !armHold && !gateDriveOutput
                                 && offCnt_q[2:0] == 3'h3;
endmodule

// File: testbench/flyback_fault_protection_bench.sv
`timescale 1ns/1ps
module flyback_fault_protection_bench;
    import fault_pkg::*;
    localparam int OVC  = 50;
    localparam int TONC = 40;
    localparam int ARC  = 60;

    logic              sys_clk = 1'b0;
    logic              reset = 1'b1;
    logic [ADDR_W-1:0] regAddr = '0;
    logic [DATA_W-1:0] regWrData = '0;
    logic              regWr = 1'b0;
    logic              regRd = 1'b0;
    logic [DATA_W-1:0] regRdData;
    logic              overloadFault = 1'b0;
    logic              normalCurrentTrip, abnormalCurrentTrip;
    logic              demagArmed, demagDetectInput;
    logic              supplyOvervoltage = 1'b0;
    logic              overTemp = 1'b0;
    logic              supplyStart = 1'b0;
    logic              supplyReset = 1'b0;
    logic              lineRemoval = 1'b0;
    logic              gateDriveOutput, faultLatched, autoRecovery, irq;
    logic [7:0]        tripAt = 8'h0a;
    logic [7:0]        abnAt = 8'h00;
    logic              abnEn = 1'b0;
    logic              detectEn = 1'b1;
    logic              armHold = 1'b0;
    int                errTotal = 0;
    int                numChecks = 0;
    int                n;
    int                k;
    logic              tonSeen = 1'b0;

    always #2.5 sys_clk = ~sys_clk;

    flyback_fault_protection #(.OVLD_CYCLES(OVC), .TON_CYCLES(TONC),
        .AR_CYCLES(ARC), .VALLEY_CYCLES(20)) i_dut (.sys_clk, .reset,
        .regAddr, .regWrData, .regWr, .regRd, .regRdData, .overloadFault,
        .normalCurrentTrip, .abnormalCurrentTrip, .demagArmed,
        .demagDetectInput, .supplyOvervoltage, .overTemp, .supplyStart,
        .supplyReset, .lineRemoval, .gateDriveOutput, .faultLatched,
        .autoRecovery, .irq);

    fault_partner i_partner (.sys_clk, .reset, .gateDriveOutput, .tripAt,
        .abnAt, .abnEn, .detectEn, .armHold, .normalCurrentTrip,
        .abnormalCurrentTrip, .demagArmed, .demagDetectInput);

    ////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic tick(input int c);
        repeat (c) @(posedge sys_clk);
        #1;
    endtask

    function automatic logic sig(input int sel);
        case (sel)
            0: return gateDriveOutput;
            1: return faultLatched;
            default: return autoRecovery;
        endcase
    endfunction

    // bounded wait for a level; running out ends the run
    task automatic waitOn(input int sel, input logic lvl, output int c);
        c = 0;
        while (sig(sel) !== lvl) begin
            if (c == 300) begin
                chk({7'h00, sig(sel)}, {7'h00, lvl});
                end_sim();
            end
            tick(1);
            c++;
        end
    endtask

    task automatic pulses(input int p);
        #1;
        repeat (p) begin
            waitOn(0, 1'b1, k);
            waitOn(0, 1'b0, k);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regAddr   <= a;
        regWrData <= d;
        regWr     <= 1'b1;
        @(posedge sys_clk);
        regWr     <= 1'b0;
    endtask

    task automatic rdChk(input logic [3:0] a, input logic [7:0] m,
                         input logic [7:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        regRd   <= 1'b1;
        @(posedge sys_clk);
        regRd   <= 1'b0;
        #1;
        chk(regRdData & m, e);
    endtask

    // bit0 start level, bit1 supply reset, bit2 line removal
    task automatic pulse(input logic [2:0] m);
        @(posedge sys_clk);
        supplyStart <= m[0];
        supplyReset <= m[1];
        lineRemoval <= m[2];
        @(posedge sys_clk);
        {lineRemoval, supplyReset, supplyStart} <= 3'h0;
        #1;
    endtask

    task automatic resetDut();
        @(posedge sys_clk);
        reset <= 1'b1;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
    endtask

    function automatic int expOn(input int t);
        return (t + 1 < TONC) ? t + 1 : TONC;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(47));
        resetDut();
        rdChk(REG_CTRL, 8'hff, CTRL_RST);
        rdChk(REG_IMASK, 8'hff, 8'h00);
        rdChk(REG_STATE, 8'hff, 8'h01);
        rdChk(4'h9, 8'hff, 8'h00);
        wr(REG_STATE, 8'hff);
        rdChk(REG_STATE, 8'hff, 8'h01);
        pulse(3'h1);
        rdChk(REG_STATE, 8'h1f, 8'h02);
        // random on-times with a blanked abnormal trip in each pulse longer than abnAt cycles
        for (int i = 0; i < 8; i++) begin
            waitOn(0, 1'b0, k);
            @(posedge sys_clk);
            tripAt <= 8'(5 + $urandom % 56);
            abnAt  <= 8'($urandom % 25);
            abnEn  <= 1'b1;
            waitOn(0, 1'b1, k);
            waitOn(0, 1'b0, n);
            tonSeen = tonSeen || tripAt >= 8'(TONC - 1);
            chk(8'(n), 8'(expOn(int'(tripAt))));
        end
        @(posedge sys_clk);
        tripAt <= 8'h0a;
        abnEn  <= 1'b0;
        pulses(1);
        chk({7'h00, faultLatched}, 8'h00);
        rdChk(REG_ISTAT, 8'hff, tonSeen ? 8'h10 : 8'h00);
        @(posedge sys_clk);
        tripAt <= 8'h3c;
        waitOn(0, 1'b1, k);
        waitOn(0, 1'b0, n);
        chk(8'(n), 8'(TONC));
        @(posedge sys_clk);
        tripAt <= 8'h0a;
        tick(1);
        chk({7'h00, irq}, 8'h00);
        wr(REG_IMASK, 8'h10);
        tick(2);
        chk({7'h00, irq}, 8'h01);
        rdChk(REG_ISTAT, 8'hff, 8'h10);
        tick(2);
        chk({7'h00, irq}, 8'h00);
        // abnormal events: three, a clean pulse, then four
        @(posedge sys_clk);
        abnAt <= 8'h19;
        tripAt <= 8'h1e;
        abnEn <= 1'b1;
        pulses(3);
        @(posedge sys_clk);
        abnEn <= 1'b0;
        pulses(1);
        @(posedge sys_clk);
        abnEn <= 1'b1;
        pulses(3);
        tick(3);
        chk({7'h00, faultLatched}, 8'h00);
        rdChk(REG_ISTAT, 8'hff, 8'h02);
        pulses(1);
        tick(2);
        chk({7'h00, faultLatched}, 8'h01);
        pulse(3'h1);
        tick(3);
        chk({faultLatched, gateDriveOutput}, 8'h02);
        pulse(3'h2);
        rdChk(REG_STATE, 8'hff, 8'h01);
        // overvoltage during an on-phase, left by line removal
        @(posedge sys_clk);
        abnEn <= 1'b0;
        tripAt <= 8'h0a;
        pulse(3'h1);
        waitOn(0, 1'b1, k);
        @(posedge sys_clk);
        supplyOvervoltage <= 1'b1;
        @(posedge sys_clk);
        supplyOvervoltage <= 1'b0;
        #1;
        chk({faultLatched, gateDriveOutput}, 8'h02);
        rdChk(REG_ISTAT, 8'h04, 8'h04);
        pulse(3'h4);
        chk({7'h00, faultLatched}, 8'h00);
        // thermal shutdown and its ways out
        pulse(3'h1);
        @(posedge sys_clk);
        overTemp <= 1'b1;
        tick(2);
        chk({faultLatched, gateDriveOutput}, 8'h00);
        rdChk(REG_STATE, 8'hff, 8'h10);
        rdChk(REG_ISTAT, 8'h08, 8'h08);
        pulse(3'h1);
        rdChk(REG_STATE, 8'hff, 8'h10);
        @(posedge sys_clk);
        overTemp <= 1'b0;
        pulse(3'h1);
        rdChk(REG_STATE, 8'h1f, 8'h02);
        @(posedge sys_clk);
        overTemp <= 1'b1;
        tick(2);
        @(posedge sys_clk);
        overTemp <= 1'b0;
        pulse(3'h2);
        rdChk(REG_STATE, 8'hff, 8'h01);
        pulse(3'h1);
        @(posedge sys_clk);
        overTemp <= 1'b1;
        tick(2);
        pulse(3'h4);
        rdChk(REG_STATE, 8'hff, 8'h01);
        pulse(3'h1);
        rdChk(REG_STATE, 8'hff, 8'h01);
        @(posedge sys_clk);
        overTemp <= 1'b0;
        pulse(3'h1);
        rdChk(REG_STATE, 8'h1f, 8'h02);
        // armed demag input: no valley timeout restart
        waitOn(0, 1'b1, k);
        @(posedge sys_clk);
        armHold <= 1'b1;
        waitOn(0, 1'b0, k);
        n = 0;
        repeat (60) begin
            tick(1);
            n += int'(gateDriveOutput === 1'b1);
        end
        chk(8'(n), 8'h00);
        @(posedge sys_clk);
        armHold <= 1'b0;
        detectEn <= 1'b0;
        waitOn(0, 1'b1, n);
        chk({7'h00, n <= 30}, 8'h01);
        @(posedge sys_clk);
        detectEn <= 1'b1;
        // integrating overload timer, latching option
        resetDut();
        pulse(3'h1);
        tick(100);
        @(posedge sys_clk);
        overloadFault <= 1'b1;
        repeat (30) @(posedge sys_clk);
        overloadFault <= 1'b0;
        repeat (10) @(posedge sys_clk);
        overloadFault <= 1'b1;
        tick(25);
        chk({7'h00, faultLatched}, 8'h00);
        waitOn(1, 1'b1, n);
        chk({7'h00, n >= 4 && n <= 7}, 8'h01);
        @(posedge sys_clk);
        overloadFault <= 1'b0;
        rdChk(REG_STATE, 8'hff, 8'h04);
        rdChk(REG_ISTAT, 8'h01, 8'h01);
        // auto-recovery option
        resetDut();
        wr(REG_CTRL, 8'h00);
        pulse(3'h1);
        rdChk(REG_STATE, 8'hff, 8'h01);
        wr(REG_CTRL, 8'h02);
        pulse(3'h1);
        @(posedge sys_clk);
        overloadFault <= 1'b1;
        waitOn(2, 1'b1, n);
        chk({7'h00, n >= OVC - 1 && n <= OVC + 3}, 8'h01);
        @(posedge sys_clk);
        overloadFault <= 1'b0;
        #1;
        chk({faultLatched, gateDriveOutput}, 8'h00);
        tick(5);
        pulse(3'h1);
        chk({7'h00, autoRecovery}, 8'h01);
        tick(ARC);
        pulse(3'h1);
        chk({7'h00, autoRecovery}, 8'h00);
        end_sim();
    end
endmodule
